// ---- shared/usbc_pkg.sv ----
package usbc_pkg;
   // Register offsets within the module (byte addresses, 8-bit registers)
   localparam logic [3:0] USBC_OFF_CTRL_A = 4'h0;
   localparam logic [3:0] USBC_OFF_CTRL_B = 4'h1;
   localparam logic [3:0] USBC_OFF_BUS_STATE = 4'h2;
   localparam logic [3:0] USBC_OFF_DEV_ADDR = 4'h3;
   localparam logic [3:0] USBC_OFF_DQ_WIDX = 4'h4;
   localparam logic [3:0] USBC_OFF_DQ_RIDX = 4'h5;
   localparam logic [3:0] USBC_OFF_IRQ_EN_BUS = 4'h6;
   localparam logic [3:0] USBC_OFF_IRQ_EN_XFER = 4'h7;
   localparam logic [3:0] USBC_OFF_EPT_LOW = 4'h8;
   localparam logic [3:0] USBC_OFF_EPT_HIGH = 4'h9;
   localparam logic [3:0] USBC_OFF_FLAGS_CLR = 4'ha;
   localparam logic [3:0] USBC_OFF_FLAGS_SET = 4'hb;
   // Field positions
   localparam int USBC_CTRLA_SPEED_BIT = 6;
   localparam int USBC_CTRLB_REFUSE_BIT = 1;
   localparam int USBC_CTRLB_ATTACH_BIT = 0;
   localparam int USBC_IEN_FRAME_BIT = 7;
   localparam int USBC_IEN_LINE_EV_BIT = 6;
   localparam int USBC_IEN_LINE_ERR_BIT = 5;
   localparam int USBC_IEN_HALT_BIT = 4;
   localparam int USBC_IEN_XFER_BIT = 1;
   localparam int USBC_IEN_CTRL_BIT = 0;
   // Reset values and masks
   localparam logic [7:0] USBC_RST_BYTE = 8'h00;
   localparam logic [7:0] USBC_CTRLB_MASK = 8'h17;
   localparam logic [7:0] USBC_IEN_BUS_MASK = 8'hf3;
   localparam logic [7:0] USBC_IEN_XFER_MASK = 8'h03;
   localparam logic [7:0] USBC_ADDR_MASK = 8'h7f;
   // Implemented table pointer width (SRAM size dependent)
   localparam int USBC_EPT_BITS = 13;
   // Timing
   localparam int USBC_CLK_HZ = 20000000;
   localparam int USBC_IDLE_US = 3000;
   localparam int USBC_SE0_NS = 2500;
   localparam int USBC_IDLE_CYC = USBC_IDLE_US * (USBC_CLK_HZ / 1000000);
   localparam int USBC_SE0_CYC = (USBC_SE0_NS * (USBC_CLK_HZ / 1000000) + 999) / 1000;
   // Line states seen by the block
   typedef enum logic [1:0] {USBC_LS_IDLE, USBC_LS_SE0, USBC_LS_ACTIVE} usbc_line_e;
   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } usbc_req_s;
   // Events from the serial engine
   typedef struct packed {
      logic frame_start;
      logic iso_crc_err;
      logic in_starved;
      logic out_refused;
      logic halt_sent;
      logic xfer_done;
      logic control_done;
      logic upstream_wake;
      logic dq_push;
   } usbc_evt_s;
endpackage

// ---- rtl/usbc_ctrl.sv ----
`timescale 1ns/1ps
// What this block does
// [RL1] Refuse-all bit NAKs all but SETUP
// [RL2] Attach bit drives speed-selected pull-up
// [RL3] Bus status four flags, upper bits zero
// [RL4] Suspended flag after 3 ms idle
// [RL5] Bus reset flag after 2.5 us SE0
// [RL6] Respond only to matching 7-bit address
// [RL7] Write index readable; write flushes queue
// [RL8] Read index readable; write flushes queue
// [RL9] Software keeps table base even
// [RL10] Unimplemented table base bits read zero
// [RL11] Frame-start enable gated by nonzero level
// [RL12] Line-event enable covers suspend/resume/reset
// [RL13] Line-error enable covers crc/under/overflow
// [RL14] Halt enable gated by nonzero level
// [RL15] Two-bit level, zero disables all
// [RL16] Transfer-done enable for IN/OUT
// [RL17] Control-done enable; upper bits read zero
// [RL18] Flags at clear and set addresses
// [RL19] Frame-start flag on SOF
// [RL20] Idle-sleep flag after 3 ms idle
// [RL21] Wake flag on activity while suspended
// [RL22] Line-reset flag on bus reset
// [RL23] Iso check error flag on CRC error
// [RL24] Starved and refused flags per direction
// [RL25] Halt flag on STALL handshake
// [RL26] Speed bit zero low, one full
// [RL27] Set beats clear in same cycle
module usbc_ctrl (
   input wire logic mclk,
   input wire logic rst,
   input wire usbc_pkg::usbc_req_s req,
   output logic [7:0] rdata,
   input wire usbc_pkg::usbc_line_e line,
   input wire usbc_pkg::usbc_evt_s evt,
   input wire logic [6:0] tok_addr,
   input wire logic tok_valid,
   input wire logic tok_setup,
   output logic addr_match,
   output logic force_nak,
   output logic sram_block,
   output logic dp_pullup,
   output logic dm_pullup,
   output logic [12:0] ep_table_base,
   output logic [4:0] dq_wr_index,
   output logic [4:0] dq_rd_index,
   output logic [7:0] wake_out,
   output logic [1:0] bus_irq_lvl,
   output logic [1:0] xfer_irq_lvl
);
   import usbc_pkg::*;

   // Whole state of the block
   typedef struct packed {
      // Software-visible registers, except xflags, which has no read path
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [3:0] bus_state;
      logic [6:0] dev_addr;
      logic [4:0] dq_w;
      logic [4:0] dq_r;
      logic [USBC_EPT_BITS-1:0] ept;
      logic [7:0] ien_bus;
      logic [1:0] ien_xfer;
      logic [7:0] flags;
      logic [1:0] xflags;
      // Line timers, saturating at their thresholds
      logic [22:0] idle_cnt;
      logic [7:0] se0_cnt;
      // Registered outputs
      logic [7:0] rdata;
      logic addr_match;
      logic force_nak;
      logic sram_block;
      logic dp_pu;
      logic dm_pu;
      logic [1:0] bus_irq;
      logic [1:0] xfer_irq;
   } usbc_state_s;

   usbc_state_s s_q;
   usbc_state_s s_d;
   logic wr_hit;
   logic [7:0] flag_evt;
   logic [1:0] lvl;
   logic bus_pend;
   logic xfer_pend;

   // Wake is a plain combinational path from the line so it works with no clock
   assign wake_out = {7'h00, s_q.bus_state[1] & (line != USBC_LS_IDLE)}; // RL21

   // Next-state logic
   always_comb begin
      s_d = s_q;
      wr_hit = req.wr;
      lvl = s_q.ien_bus[1:0];
      // Idle counter: saturates; suspend flag when reached
      if (line == USBC_LS_IDLE) begin
         if (s_q.idle_cnt < 23'(USBC_IDLE_CYC)) begin
            s_d.idle_cnt = s_q.idle_cnt + 23'd1;
         end
      end else begin
         s_d.idle_cnt = 23'd0;
      end
      // SE0 counter for bus reset
      if (line == USBC_LS_SE0) begin
         if (s_q.se0_cnt < 8'(USBC_SE0_CYC)) begin
            s_d.se0_cnt = s_q.se0_cnt + 8'd1;
         end
      end else begin
         s_d.se0_cnt = 8'd0;
      end
      s_d.bus_state[1] = (s_d.idle_cnt == 23'(USBC_IDLE_CYC)); // RL4
      s_d.bus_state[0] = (s_d.se0_cnt == 8'(USBC_SE0_CYC)); // RL5
      // Downstream resume: activity while suspended
      if (s_q.bus_state[1] && line == USBC_LS_ACTIVE) begin
         s_d.bus_state[2] = 1'b1;
      end else if (line == USBC_LS_IDLE && s_d.bus_state[1]) begin
         s_d.bus_state[2] = 1'b0;
      end
      if (evt.upstream_wake) begin
         s_d.bus_state[3] = 1'b1; // RL3
      end else if (s_q.bus_state[1] && !s_d.bus_state[1]) begin
         // Held until the bus leaves suspend so software can still see it
         s_d.bus_state[3] = 1'b0;
      end
      // Hardware events into flag bits
      flag_evt = {evt.frame_start, // RL19
                  s_d.bus_state[1] & ~s_q.bus_state[1], // RL20
                  s_q.bus_state[1] & (line != USBC_LS_IDLE), // RL21
                  s_d.bus_state[0] & ~s_q.bus_state[0], // RL22
                  evt.iso_crc_err, // RL23
                  evt.in_starved, evt.out_refused, // RL24
                  evt.halt_sent}; // RL25
      // Register writes
      if (wr_hit) begin
         case (req.addr)
            USBC_OFF_CTRL_A: s_d.ctrl_a = req.wdata;
            USBC_OFF_CTRL_B: s_d.ctrl_b = req.wdata & USBC_CTRLB_MASK;
            USBC_OFF_DEV_ADDR: s_d.dev_addr = req.wdata[6:0]; // RL6
            USBC_OFF_DQ_WIDX, USBC_OFF_DQ_RIDX: begin
               s_d.dq_w = 5'd0; // RL7
               s_d.dq_r = 5'd0; // RL8
            end
            USBC_OFF_EPT_LOW: s_d.ept[7:0] = req.wdata;
            USBC_OFF_EPT_HIGH: s_d.ept[USBC_EPT_BITS-1:8] = req.wdata[USBC_EPT_BITS-9:0]; // RL10
            USBC_OFF_IRQ_EN_BUS: s_d.ien_bus = req.wdata & USBC_IEN_BUS_MASK;
            USBC_OFF_IRQ_EN_XFER: s_d.ien_xfer = req.wdata[1:0]; // RL17
            USBC_OFF_FLAGS_CLR: s_d.flags = s_q.flags & ~req.wdata; // RL18
            USBC_OFF_FLAGS_SET: s_d.flags = s_q.flags | req.wdata; // RL18
            default: begin
            end
         endcase
      end
      // Queue pointer advance when no flush is written this cycle
      if (evt.dq_push && !(wr_hit && (req.addr == USBC_OFF_DQ_WIDX ||
                                      req.addr == USBC_OFF_DQ_RIDX))) begin
         s_d.dq_w = s_q.dq_w + 5'd1;
      end
      // Events applied last so a set wins over a same-cycle clear
      s_d.flags = s_d.flags | flag_evt; // RL27
      s_d.xflags = s_q.xflags | {evt.xfer_done, evt.control_done};
      // Read mux; unmapped offsets read zero
      case (req.addr)
         USBC_OFF_CTRL_A: s_d.rdata = s_q.ctrl_a;
         USBC_OFF_CTRL_B: s_d.rdata = s_q.ctrl_b;
         USBC_OFF_BUS_STATE: s_d.rdata = {4'h0, s_q.bus_state}; // RL3
         USBC_OFF_DEV_ADDR: s_d.rdata = {1'b0, s_q.dev_addr};
         USBC_OFF_DQ_WIDX: s_d.rdata = {3'h0, s_q.dq_w}; // RL7
         USBC_OFF_DQ_RIDX: s_d.rdata = {3'h0, s_q.dq_r}; // RL8
         USBC_OFF_EPT_LOW: s_d.rdata = s_q.ept[7:0];
         USBC_OFF_EPT_HIGH: s_d.rdata = {3'h0, s_q.ept[USBC_EPT_BITS-1:8]}; // RL10
         USBC_OFF_IRQ_EN_BUS: s_d.rdata = s_q.ien_bus;
         USBC_OFF_IRQ_EN_XFER: s_d.rdata = {6'h00, s_q.ien_xfer}; // RL17
         USBC_OFF_FLAGS_CLR, USBC_OFF_FLAGS_SET: s_d.rdata = s_q.flags; // RL18
         default: s_d.rdata = 8'h00;
      endcase
      // Address filter and global refuse
      s_d.addr_match = tok_valid && (tok_addr == s_q.dev_addr); // RL6
      s_d.force_nak = tok_valid && !tok_setup && s_q.ctrl_b[USBC_CTRLB_REFUSE_BIT]; // RL1
      s_d.sram_block = s_d.force_nak; // RL1
      // Pull-up follows attach and speed
      s_d.dp_pu = s_q.ctrl_b[USBC_CTRLB_ATTACH_BIT] && s_q.ctrl_a[USBC_CTRLA_SPEED_BIT]; // RL2
      s_d.dm_pu = s_q.ctrl_b[USBC_CTRLB_ATTACH_BIT] && !s_q.ctrl_a[USBC_CTRLA_SPEED_BIT]; // RL26
      // Interrupt request per vector
      bus_pend = (s_q.ien_bus[USBC_IEN_FRAME_BIT] && s_q.flags[7]) || // RL11
                 (s_q.ien_bus[USBC_IEN_LINE_EV_BIT] && |s_q.flags[6:4]) || // RL12
                 (s_q.ien_bus[USBC_IEN_LINE_ERR_BIT] && |s_q.flags[3:1]) || // RL13
                 (s_q.ien_bus[USBC_IEN_HALT_BIT] && s_q.flags[0]); // RL14
      xfer_pend = (s_q.ien_xfer[USBC_IEN_XFER_BIT] && s_q.xflags[1]) || // RL16
                  (s_q.ien_xfer[USBC_IEN_CTRL_BIT] && s_q.xflags[0]); // RL17
      s_d.bus_irq = bus_pend ? lvl : 2'b00; // RL15
      s_d.xfer_irq = xfer_pend ? lvl : 2'b00; // RL15
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign rdata = s_q.rdata;
   assign addr_match = s_q.addr_match;
   assign force_nak = s_q.force_nak;
   assign sram_block = s_q.sram_block;
   assign dp_pullup = s_q.dp_pu;
   assign dm_pullup = s_q.dm_pu;
   assign ep_table_base = {s_q.ept[USBC_EPT_BITS-1:1], 1'b0}; // RL9
   assign dq_wr_index = s_q.dq_w;
   assign dq_rd_index = s_q.dq_r;
   assign bus_irq_lvl = s_q.bus_irq;
   assign xfer_irq_lvl = s_q.xfer_irq;

   // Checks
   property p_refuse;
      @(posedge mclk) disable iff (rst)
      (tok_valid && !tok_setup && s_q.ctrl_b[1]) |=> force_nak && sram_block;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refuse-all not applied"); // RL1
   property p_attach;
      @(posedge mclk) disable iff (rst)
      !s_q.ctrl_b[0] |=> !dp_pullup && !dm_pullup;
   endproperty
   a_attach: assert property (p_attach) else $error("pull-up while detached"); // RL2
   property p_speed;
      @(posedge mclk) disable iff (rst)
      (s_q.ctrl_b[0] && !s_q.ctrl_a[6]) |=> dm_pullup && !dp_pullup;
   endproperty
   a_speed: assert property (p_speed) else $error("low speed pull-up wrong"); // RL26
   property p_se0;
      @(posedge mclk) disable iff (rst)
      (line == USBC_LS_SE0) [*8] |-> ##[1:50] s_q.bus_state[0] || line != USBC_LS_SE0;
   endproperty
   a_se0: assert property (p_se0) else $error("bus reset not flagged"); // RL5
   property p_flush;
      @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == USBC_OFF_DQ_RIDX) |=> dq_rd_index == 5'd0 && dq_wr_index == 5'd0;
   endproperty
   a_flush: assert property (p_flush) else $error("queue not flushed"); // RL8
   property p_setwins;
      @(posedge mclk) disable iff (rst)
      (evt.halt_sent && req.wr && req.addr == USBC_OFF_FLAGS_CLR) |=> s_q.flags[0];
   endproperty
   a_setwins: assert property (p_setwins) else $error("event lost to clear"); // RL27
   property p_lvl0;
      @(posedge mclk) disable iff (rst)
      $past(s_q.ien_bus[1:0]) == 2'b00 |-> bus_irq_lvl == 2'b00 && xfer_irq_lvl == 2'b00;
   endproperty
   a_lvl0: assert property (p_lvl0) else $error("request with level zero"); // RL15
   property p_status_hi;
      @(posedge mclk) disable iff (rst)
      ($past(req.addr) == USBC_OFF_BUS_STATE) |-> rdata[7:4] == 4'h0;
   endproperty
   a_status_hi: assert property (p_status_hi) else $error("status upper bits set"); // RL3
   // Per-source checks on flags, filters, pull-ups, timers, queue flush and request gating
   property p_match;
      @(posedge mclk) disable iff (rst)
      (tok_valid && tok_addr != s_q.dev_addr) |=> !addr_match;
   endproperty
   a_match: assert property (p_match) else $error("foreign address matched"); // RL6
   property p_setup;
      @(posedge mclk) disable iff (rst)
      (tok_valid && tok_setup) |=> !force_nak && !sram_block;
   endproperty
   a_setup: assert property (p_setup) else $error("setup refused"); // RL1
   property p_full;
      @(posedge mclk) disable iff (rst)
      (s_q.ctrl_b[0] && s_q.ctrl_a[6]) |=> dp_pullup && !dm_pullup;
   endproperty
   a_full: assert property (p_full) else $error("full speed pull-up wrong"); // RL2
   property p_susp_early;
      @(posedge mclk) disable iff (rst)
      s_q.bus_state[1] |-> s_q.idle_cnt == 23'(USBC_IDLE_CYC);
   endproperty
   a_susp_early: assert property (p_susp_early) else $error("suspend too early"); // RL4
   property p_se0_early;
      @(posedge mclk) disable iff (rst)
      s_q.bus_state[0] |-> s_q.se0_cnt == 8'(USBC_SE0_CYC);
   endproperty
   a_se0_early: assert property (p_se0_early) else $error("bus reset too early"); // RL5
   property p_flush_w;
      @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == USBC_OFF_DQ_WIDX) |=> dq_rd_index == 5'd0 && dq_wr_index == 5'd0;
   endproperty
   a_flush_w: assert property (p_flush_w) else $error("queue not flushed"); // RL7
   property p_fset;
      @(posedge mclk) disable iff (rst)
      (req.wr && req.addr == USBC_OFF_FLAGS_SET) |=>
         (s_q.flags & $past(req.wdata)) == $past(req.wdata);
   endproperty
   a_fset: assert property (p_fset) else $error("flag not set by write"); // RL18
   property p_frame;
      @(posedge mclk) disable iff (rst)
      evt.frame_start |=> s_q.flags[7];
   endproperty
   a_frame: assert property (p_frame) else $error("frame flag missed"); // RL19
   property p_susp_flag;
      @(posedge mclk) disable iff (rst)
      $rose(s_q.bus_state[1]) |-> s_q.flags[6];
   endproperty
   a_susp_flag: assert property (p_susp_flag) else $error("sleep flag missed"); // RL20
   property p_wake;
      @(posedge mclk) disable iff (rst)
      (s_q.bus_state[1] && line != USBC_LS_IDLE) |=> s_q.flags[5];
   endproperty
   a_wake: assert property (p_wake) else $error("wake flag missed"); // RL21
   property p_rst_flag;
      @(posedge mclk) disable iff (rst)
      $rose(s_q.bus_state[0]) |-> s_q.flags[4];
   endproperty
   a_rst_flag: assert property (p_rst_flag) else $error("line reset flag missed"); // RL22
   property p_iso;
      @(posedge mclk) disable iff (rst)
      evt.iso_crc_err |=> s_q.flags[3];
   endproperty
   a_iso: assert property (p_iso) else $error("check error flag missed"); // RL23
   property p_starved;
      @(posedge mclk) disable iff (rst)
      evt.in_starved |=> s_q.flags[2];
   endproperty
   a_starved: assert property (p_starved) else $error("starved flag missed"); // RL24
   property p_refused;
      @(posedge mclk) disable iff (rst)
      evt.out_refused |=> s_q.flags[1];
   endproperty
   a_refused: assert property (p_refused) else $error("refused flag missed"); // RL24
   property p_sof_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_bus[7] && s_q.flags[7] && |s_q.ien_bus[1:0]) |=>
         bus_irq_lvl == $past(s_q.ien_bus[1:0]);
   endproperty
   a_sof_irq: assert property (p_sof_irq) else $error("frame request missing"); // RL11
   property p_ev_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_bus[6] && |s_q.flags[6:4] && |s_q.ien_bus[1:0]) |=> bus_irq_lvl != 2'b00;
   endproperty
   a_ev_irq: assert property (p_ev_irq) else $error("line event request missing"); // RL12
   property p_err_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_bus[5] && |s_q.flags[3:1] && |s_q.ien_bus[1:0]) |=> bus_irq_lvl != 2'b00;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("line error request missing"); // RL13
   property p_halt_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_bus[4] && s_q.flags[0] && |s_q.ien_bus[1:0]) |=> bus_irq_lvl != 2'b00;
   endproperty
   a_halt_irq: assert property (p_halt_irq) else $error("halt request missing"); // RL14
   property p_trn_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_xfer[1] && s_q.xflags[1] && |s_q.ien_bus[1:0]) |=> xfer_irq_lvl != 2'b00;
   endproperty
   a_trn_irq: assert property (p_trn_irq) else $error("transfer request missing"); // RL16
   property p_ctl_irq;
      @(posedge mclk) disable iff (rst)
      (s_q.ien_xfer[0] && s_q.xflags[0] && |s_q.ien_bus[1:0]) |=> xfer_irq_lvl != 2'b00;
   endproperty
   a_ctl_irq: assert property (p_ctl_irq) else $error("control request missing"); // RL17
   property p_xfer_off;
      @(posedge mclk) disable iff (rst)
      s_q.ien_xfer == 2'b00 |=> xfer_irq_lvl == 2'b00;
   endproperty
   a_xfer_off: assert property (p_xfer_off) else $error("request with no enable"); // RL16
   // Main scenarios that the bench should reach
   c_suspend: cover property (@(posedge mclk) disable iff (rst) $rose(s_q.bus_state[1]));
   c_irq: cover property (@(posedge mclk) disable iff (rst) bus_irq_lvl != 2'b00);
   c_nak: cover property (@(posedge mclk) disable iff (rst) force_nak);
   c_wake: cover property (@(posedge mclk) disable iff (rst) $rose(s_q.flags[5]));
   c_match: cover property (@(posedge mclk) disable iff (rst) addr_match);
endmodule

// ---- verif/usbc_host_model.sv ----
`timescale 1ns/1ps
// Host and serial engine stand-in: line state, event pulses and tokens
module usbc_host_model (
   input wire logic mclk,
   output usbc_pkg::usbc_line_e line,
   output usbc_pkg::usbc_evt_s evt,
   output logic [6:0] tok_addr,
   output logic tok_valid,
   output logic tok_setup
);
   import usbc_pkg::*;
   // Bus starts busy so the idle timer stays quiet until a test wants it
   initial begin
      line = USBC_LS_ACTIVE;
      evt = '0;
      tok_addr = 7'h55;
      tok_valid = 1'b0;
      tok_setup = 1'b0;
   end
   // Put the line in a state and keep it there for n cycles
   task automatic hold(input usbc_line_e s, input int n);
      @(posedge mclk);
      #1;
      line = s;
      repeat (n) @(posedge mclk);
   endtask
   // One-cycle event pulse
   task automatic ev(input usbc_evt_s e);
      @(posedge mclk);
      #1;
      evt = e;
      @(posedge mclk);
      #1;
      evt = '0;
   endtask
   // Token pulse; the address is scrambled afterwards so a stale value never helps
   task automatic tok(input logic [6:0] a, input logic s);
      @(posedge mclk);
      #1;
      tok_addr = a;
      tok_setup = s;
      tok_valid = 1'b1;
      @(posedge mclk);
      #1;
      tok_valid = 1'b0;
      tok_addr = ~a;
      tok_setup = ~s;
   endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import usbc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   usbc_req_s req = '0;
   usbc_line_e line;
   usbc_evt_s evt;
   logic [6:0] tok_addr;
   logic tok_valid, tok_setup, addr_match, force_nak, sram_block, dp_pullup, dm_pullup;
   logic [12:0] ep_table_base;
   logic [4:0] dq_wr_index, dq_rd_index;
   logic [7:0] rdata, wake_out;
   logic [1:0] bus_irq_lvl, xfer_irq_lvl;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   // 20 MHz system clock
   always #25 mclk = ~mclk;
   usbc_ctrl u_dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .line(line), .evt(evt),
      .tok_addr(tok_addr), .tok_valid(tok_valid), .tok_setup(tok_setup),
      .addr_match(addr_match), .force_nak(force_nak), .sram_block(sram_block),
      .dp_pullup(dp_pullup), .dm_pullup(dm_pullup), .ep_table_base(ep_table_base),
      .dq_wr_index(dq_wr_index), .dq_rd_index(dq_rd_index), .wake_out(wake_out),
      .bus_irq_lvl(bus_irq_lvl), .xfer_irq_lvl(xfer_irq_lvl));
   usbc_host_model u_host (.mclk(mclk), .line(line), .evt(evt), .tok_addr(tok_addr),
      .tok_valid(tok_valid), .tok_setup(tok_setup));
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Register write: held for one taking edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      #1;
      req.wr = 1'b0;
   endtask
   // Register read under a mask; rdata lands one cycle after the address
   task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge mclk);
      #1;
      req.rd = 1'b1;
      req.addr = a;
      repeat (2) @(posedge mclk);
      #1;
      chk(rdata & m, exp);
      req.rd = 1'b0;
   endtask
   // Interrupt outputs trail the flag by one cycle
   task automatic w2();
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic t_reset();
      logic [3:0] a [6] = '{4'h2, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc};
      for (int i = 0; i < 6; i++) rchk(a[i], 8'hff, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_flags();
      wr(USBC_OFF_FLAGS_SET, 8'h81);
      rchk(USBC_OFF_FLAGS_CLR, 8'hff, 8'h81);
      rchk(USBC_OFF_FLAGS_SET, 8'hff, 8'h81);
      wr(USBC_OFF_FLAGS_CLR, 8'h01);
      wr(USBC_OFF_FLAGS_SET, 8'h00);
      rchk(USBC_OFF_FLAGS_SET, 8'hff, 8'h80);
      $display("test flags done");
   endtask
   // Each flag against its group enable, level zero, then other enables only
   task automatic t_irq();
      logic [7:0] en [8] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h20, 8'h20, 8'h20, 8'h10};
      logic [7:0] lv;
      for (int i = 0; i < 8; i++) begin
         lv = 8'(i % 3 + 1);
         wr(USBC_OFF_FLAGS_CLR, 8'hff);
         wr(USBC_OFF_IRQ_EN_BUS, en[i]);
         wr(USBC_OFF_FLAGS_SET, 8'h80 >> i);
         w2();
         chk(bus_irq_lvl, 2'h0);
         wr(USBC_OFF_IRQ_EN_BUS, en[i] | lv);
         w2();
         chk(bus_irq_lvl, lv);
         wr(USBC_OFF_IRQ_EN_BUS, (~en[i] & 8'hf0) | lv);
         w2();
         chk(bus_irq_lvl, 2'h0);
      end
      wr(USBC_OFF_IRQ_EN_BUS, 8'hff);
      rchk(USBC_OFF_IRQ_EN_BUS, 8'hff, 8'hf3);
      wr(USBC_OFF_IRQ_EN_BUS, 8'h00);
      $display("test irq done");
   endtask
   task automatic t_events();
      for (int i = 0; i < 5; i++) begin
         wr(USBC_OFF_FLAGS_CLR, 8'hff);
         u_host.ev(usbc_evt_s'(9'h100 >> i));
         rchk(USBC_OFF_FLAGS_CLR, 8'hff, (i == 0) ? 8'h80 : 8'h10 >> i);
      end
      // Halt event in the very cycle software clears it: the event wins
      fork
         wr(USBC_OFF_FLAGS_CLR, 8'h01);
         u_host.ev(usbc_evt_s'(9'h010));
      join
      rchk(USBC_OFF_FLAGS_CLR, 8'h01, 8'h01);
      u_host.ev(usbc_evt_s'(9'h002));
      wr(USBC_OFF_BUS_STATE, 8'hff);
      rchk(USBC_OFF_BUS_STATE, 8'hff, 8'h08);
      $display("test events done");
   endtask
   task automatic t_addr();
      wr(USBC_OFF_DEV_ADDR, 8'hff);
      rchk(USBC_OFF_DEV_ADDR, 8'hff, 8'h7f);
      u_host.tok(7'h7f, 1'b0);
      chk({addr_match, force_nak}, 2'h2);
      u_host.tok(7'h7e, 1'b0);
      chk(addr_match, 1'b0);
      wr(USBC_OFF_CTRL_B, 8'h02);
      u_host.tok(7'h7f, 1'b0);
      chk({force_nak, sram_block}, 2'h3);
      u_host.tok(7'h7f, 1'b1);
      chk(force_nak, 1'b0);
      // Pull-ups sit one register behind the control bits
      wr(USBC_OFF_CTRL_B, 8'h01);
      w2();
      chk({dp_pullup, dm_pullup}, 2'h1);
      wr(USBC_OFF_CTRL_A, 8'h40);
      w2();
      chk({dp_pullup, dm_pullup}, 2'h2);
      wr(USBC_OFF_CTRL_B, 8'h00);
      w2();
      chk({dp_pullup, dm_pullup}, 2'h0);
      $display("test address and attach done");
   endtask
   task automatic t_queue();
      repeat (3) u_host.ev(usbc_evt_s'(9'h001));
      chk(dq_wr_index, 5'h03);
      rchk(USBC_OFF_DQ_WIDX, 8'hff, 8'h03);
      wr(USBC_OFF_DQ_RIDX, 8'h00);
      chk({dq_wr_index, dq_rd_index}, 10'h000);
      u_host.ev(usbc_evt_s'(9'h001));
      wr(USBC_OFF_DQ_WIDX, 8'h00);
      chk(dq_wr_index, 5'h00);
      rchk(USBC_OFF_DQ_RIDX, 8'hff, 8'h00);
      wr(USBC_OFF_EPT_LOW, 8'h34);
      wr(USBC_OFF_EPT_HIGH, 8'hff);
      rchk(USBC_OFF_EPT_HIGH, 8'hff, 8'h1f);
      chk(ep_table_base, 13'h1f34);
      $display("test queue and table done");
   endtask
   task automatic t_xfer();
      wr(USBC_OFF_IRQ_EN_XFER, 8'hff);
      rchk(USBC_OFF_IRQ_EN_XFER, 8'hff, 8'h03);
      wr(USBC_OFF_IRQ_EN_BUS, 8'h01);
      wr(USBC_OFF_IRQ_EN_XFER, 8'h02);
      u_host.ev(usbc_evt_s'(9'h004));
      w2();
      chk(xfer_irq_lvl, 2'h0);
      wr(USBC_OFF_IRQ_EN_XFER, 8'h01);
      w2();
      chk(xfer_irq_lvl, 2'h1);
      u_host.ev(usbc_evt_s'(9'h008));
      wr(USBC_OFF_IRQ_EN_XFER, 8'h02);
      wr(USBC_OFF_IRQ_EN_BUS, 8'h03);
      w2();
      chk(xfer_irq_lvl, 2'h3);
      wr(USBC_OFF_IRQ_EN_BUS, 8'h00);
      w2();
      chk(xfer_irq_lvl, 2'h0);
      $display("test transfer irq done");
   endtask
   // Short SE0 must not count as reset; long idle suspends; activity wakes
   task automatic t_lines();
      wr(USBC_OFF_FLAGS_CLR, 8'hff);
      u_host.hold(USBC_LS_SE0, 40);
      rchk(USBC_OFF_BUS_STATE, 8'h01, 8'h00);
      u_host.hold(USBC_LS_ACTIVE, 5);
      u_host.hold(USBC_LS_SE0, 60);
      rchk(USBC_OFF_BUS_STATE, 8'h01, 8'h01);
      rchk(USBC_OFF_FLAGS_CLR, 8'h10, 8'h10);
      u_host.hold(USBC_LS_IDLE, USBC_IDLE_CYC + 20);
      rchk(USBC_OFF_BUS_STATE, 8'h02, 8'h02);
      rchk(USBC_OFF_FLAGS_CLR, 8'h40, 8'h40);
      u_host.hold(USBC_LS_ACTIVE, 0);
      #1;
      chk(wake_out, 8'h01);
      rchk(USBC_OFF_FLAGS_CLR, 8'h20, 8'h20);
      rchk(USBC_OFF_BUS_STATE, 8'h0e, 8'h04);
      $display("test lines done");
   endtask
   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Ceiling well above the long idle wait
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_flags();
      t_irq();
      t_events();
      t_addr();
      t_queue();
      t_xfer();
      t_lines();
      stop_test();
   end
endmodule
